// ===== hdl/cmd_handler.sv
// Purpose: antenna channel, slot and tag sequence command handler
// Assumes: host feeds command bytes and drains response bytes over AXI4-Lite
// Notes: one command in flight; new bytes refused until response drained
// Functional notes
// - set channel command 002AH stores one byte
// - channel byte 01H..04H channel, 05H off
// - set channel answer echoes code only
// - get channel returns code and stored byte
// - version query returns code and 13 bytes
// - version query unconditional, handled at once
// - set slot 0030H stores byte, echoes code
// - slot byte only 1, 2 or 3
// - get slot returns code and stored byte
// - set sequence: reserved 00H, protocol/config, antenna
// - protocol identifier 4 means Title 21
// - configuration id 0 no ack, 1 ack
// - antenna number ranges 0 to 03H
// - code is two bytes, high byte 00H first
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module cmd_handler
   import cmd_handler_pkg::*;
#(
   parameter int          ADDR_W  = 8,             // axi address width
   parameter logic [103:0] VERSION = 104'h0        // table version, arbitrary value
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output cfg_t                   cfg,
   output logic                   seq_reset_req
);

   // reset value of the stored settings
   localparam cfg_t CFG_RST = '{chan: `CHAN_RST, slot: `SLOT_RST, proto: `PROTO_T21,
                                ack_cfg: `ACK_RST, antenna: `ANT_RST};

   // refuse address widths the decoder cannot serve
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("cmd_handler: ADDR_W must be at least 8");
   end

   state_t s;        // registered state
   state_t next_s;   // next state
   logic [7:0] ar_off;   // read offset, word aligned
   logic       ar_hi;    // read address above the map
   logic [7:0] w_off;    // held write offset, word aligned
   logic [15:0] code;    // received command code
   logic [7:0]  arg;     // first parameter byte

   // handshake outputs straight from state
   assign awready = !s.aw_held && !s.bvalid;
   assign wready  = !s.w_held && !s.bvalid;
   assign arready = !s.rvalid;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;
   assign cfg     = s.cfg;
   assign seq_reset_req = s.seq_changed;

   // address split: low byte decodes, upper bits must be zero
   assign ar_off = {araddr[7:2], 2'b00};
   assign ar_hi  = (araddr >> 8) != '0;
   assign w_off  = {s.aw_off[7:2], 2'b00};
   assign code   = {s.cmd_buf[0], s.cmd_buf[1]};
   assign arg    = s.cmd_buf[2];

   // all next-state logic
   always_comb
   begin
      logic [7:0] rsp_lo;   // low byte of answer code
      logic       bad;      // parameter or length fault
      logic       unknown;  // code not handled here
      logic       seq_set;  // sequence accepted this cycle
      logic       seq_clr;  // host acknowledged the reset
      logic       ovr_set;  // refused command byte
      logic       ovr_clr;  // host cleared overrun
      rsp_lo  = code[7:0];
      bad     = 1'b0;
      unknown = 1'b0;
      seq_set = 1'b0;
      seq_clr = 1'b0;
      ovr_set = 1'b0;
      ovr_clr = 1'b0;
      next_s  = s;

      // write address and data are taken in either order
      if (awvalid && awready)
      begin
         next_s.aw_held = 1'b1;
         next_s.aw_off  = awaddr[7:0];
         next_s.aw_hi   = (awaddr >> 8) != '0;
      end
      if (wvalid && wready)
      begin
         next_s.w_held = 1'b1;
         next_s.wdata  = wdata;
         next_s.wstrb  = wstrb;
      end
      // response retires when the master takes it
      if (s.bvalid && bready)
      begin
         next_s.bvalid = 1'b0;
      end

      // both halves held: perform the write
      if (s.aw_held && s.w_held && !s.bvalid)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = `RESP_OKAY;
         if (s.aw_hi)
         begin
            // outside the map
            next_s.bresp = `RESP_SLVERR;
         end
         else if (w_off == `OFS_CMD_DATA)
         begin
            if (s.phase != PH_COLLECT)
            begin
               // byte arrives while busy: dropped, flagged
               ovr_set = 1'b1;
            end
            else if (s.wstrb[0])
            begin
               if (s.cmd_cnt < 4'(`CMD_MAX))
               begin
                  next_s.cmd_buf[s.cmd_cnt[2:0]] = s.wdata[7:0];
                  next_s.cmd_cnt = s.cmd_cnt + 4'h1;
               end
               else
               begin
                  // too long for any command here
                  next_s.cmd_ovf = 1'b1;
               end
               // last byte of the message starts execution
               if (s.wstrb[1] && s.wdata[`BIT_LAST])
               begin
                  next_s.phase = PH_EXEC;
               end
            end
         end
         else if (w_off == `OFS_CTRL)
         begin
            if (s.wstrb[0] && s.wdata[`BIT_FLUSH])
            begin
               // abandon partial command or unread answer
               next_s.phase   = PH_COLLECT;
               next_s.cmd_cnt = 4'h0;
               next_s.cmd_ovf = 1'b0;
               next_s.rsp_len = 4'h0;
               next_s.rsp_ptr = 4'h0;
            end
            seq_clr = s.wstrb[0] && s.wdata[`BIT_SEQ_ACK];
            ovr_clr = s.wstrb[0] && s.wdata[`BIT_OVR_CLR];
         end
         else if (w_off == `OFS_RSP_DATA || w_off == `OFS_STATUS ||
                  w_off == `OFS_CHAN || w_off == `OFS_SLOT || w_off == `OFS_SEQ)
         begin
            // read-only registers ignore writes
            next_s.bresp = `RESP_OKAY;
         end
         else
         begin
            next_s.bresp = `RESP_SLVERR;
         end
      end

      // command execution, one cycle after the last byte
      if (s.phase == PH_EXEC)
      begin
         next_s.rsp_buf = '0;
         next_s.rsp_len = `LEN_CODE;
         next_s.rsp_ptr = 4'h0;
         next_s.cmd_cnt = 4'h0;
         next_s.cmd_ovf = 1'b0;
         next_s.phase   = PH_RESPOND;
         if (s.cmd_ovf || s.cmd_cnt < `LEN_CODE || code[15:8] != `CODE_HI)
         begin
            // high byte other than 00H is not ours
            unknown = s.cmd_cnt >= `LEN_CODE && !s.cmd_ovf;
            bad     = !unknown;
         end
         else
         begin
            unique case (code[7:0])
               `CODE_SET_CH:
               begin
                  bad = s.cmd_cnt != `LEN_ONE || arg < `CHAN_MIN || arg > `CHAN_MAX;
                  if (!bad)
                  begin
                     next_s.cfg.chan = arg;
                  end
               end
               `CODE_GET_CH:
               begin
                  bad = s.cmd_cnt != `LEN_CODE;
                  next_s.rsp_buf[2] = s.cfg.chan;
                  next_s.rsp_len    = `LEN_ONE;
               end
               `CODE_GET_VER:
               begin
                  bad = s.cmd_cnt != `LEN_CODE;
                  for (int i = 0; i < `VER_BYTES; i++)
                  begin
                     next_s.rsp_buf[i+2] = VERSION[8*(`VER_BYTES-1-i) +: 8];
                  end
                  next_s.rsp_len = 4'(`VER_BYTES + 2);
               end
               `CODE_SET_SL:
               begin
                  // slot only 1, 2 or 3
                  bad = s.cmd_cnt != `LEN_ONE || arg < `SLOT_MIN || arg > `SLOT_MAX;
                  if (!bad)
                  begin
                     next_s.cfg.slot = arg;
                  end
               end
               `CODE_GET_SL:
               begin
                  bad = s.cmd_cnt != `LEN_CODE;
                  next_s.rsp_buf[2] = s.cfg.slot;
                  next_s.rsp_len    = `LEN_ONE;
               end
               `CODE_SET_SEQ:
               begin
                  bad = s.cmd_cnt != `LEN_SEQ || arg != `SEQ_RSVD ||
                        s.cmd_buf[3][7:4] != `PROTO_T21 ||
                        s.cmd_buf[3][3:0] > `ACK_MAX || s.cmd_buf[4] > `ANT_MAX;
                  if (!bad)
                  begin
                     next_s.cfg.proto   = s.cmd_buf[3][7:4];
                     next_s.cfg.ack_cfg = s.cmd_buf[3][3:0];
                     next_s.cfg.antenna = s.cmd_buf[4];
                     seq_set = 1'b1;
                  end
               end
               default:
               begin
                  unknown = 1'b1;
               end
            endcase
         end
         if (unknown)
         begin
            next_s.rsp_buf[0] = `ERR_HI;
            next_s.rsp_buf[1] = `ERR_SUB_LO;
            next_s.rsp_buf[2] = code[15:8];
            next_s.rsp_buf[3] = code[7:0];
            next_s.rsp_len    = `LEN_SUBERR;
         end
         else if (bad)
         begin
            next_s.rsp_buf    = '0;
            next_s.rsp_buf[0] = `ERR_HI;
            next_s.rsp_buf[1] = `ERR_DATA_LO;
            next_s.rsp_len    = `LEN_CODE;
         end
         else
         begin
            next_s.rsp_buf[0] = `CODE_HI;
            next_s.rsp_buf[1] = rsp_lo;
         end
         next_s.last_err = bad || unknown;
      end

      // read channel: data registered, answered next cycle
      if (s.rvalid && rready)
      begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         if (ar_hi)
         begin
            next_s.rresp = `RESP_SLVERR;
         end
         else if (ar_off == `OFS_RSP_DATA)
         begin
            // reading pops one byte; bit 8 marks it valid
            if (s.phase == PH_RESPOND && s.rsp_ptr < s.rsp_len)
            begin
               next_s.rdata[7:0]       = s.rsp_buf[s.rsp_ptr];
               next_s.rdata[`BIT_LAST] = 1'b1;
               next_s.rsp_ptr          = s.rsp_ptr + 4'h1;
               if (s.rsp_ptr + 4'h1 == s.rsp_len)
               begin
                  // last byte drained, accept the next command
                  next_s.phase = PH_COLLECT;
               end
            end
         end
         else if (ar_off == `OFS_STATUS)
         begin
            next_s.rdata[0]     = s.phase == PH_RESPOND;
            next_s.rdata[1]     = s.phase == PH_EXEC;
            next_s.rdata[2]     = s.last_err;
            next_s.rdata[3]     = s.overrun;
            next_s.rdata[4]     = s.seq_changed;
            next_s.rdata[11:8]  = s.rsp_len - s.rsp_ptr;
            next_s.rdata[15:12] = s.cmd_cnt;
         end
         else if (ar_off == `OFS_CHAN)
         begin
            next_s.rdata[7:0] = s.cfg.chan;
         end
         else if (ar_off == `OFS_SLOT)
         begin
            next_s.rdata[7:0] = s.cfg.slot;
         end
         else if (ar_off == `OFS_SEQ)
         begin
            next_s.rdata[7:0]  = {s.cfg.proto, s.cfg.ack_cfg};
            next_s.rdata[15:8] = s.cfg.antenna;
         end
         else if (ar_off == `OFS_CMD_DATA || ar_off == `OFS_CTRL)
         begin
            // write-only registers read as zero
            next_s.rdata = 32'h0000_0000;
         end
         else
         begin
            next_s.rresp = `RESP_SLVERR;
         end
      end

      // host must reset reader; flag set wins over ack
      if (seq_set)
      begin
         next_s.seq_changed = 1'b1;
      end
      else if (seq_clr)
      begin
         next_s.seq_changed = 1'b0;
      end
      // overrun flag, set wins over clear
      if (ovr_set)
      begin
         next_s.overrun = 1'b1;
      end
      else if (ovr_clr)
      begin
         next_s.overrun = 1'b0;
      end
   end

   // state register, synchronous active-low reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s     <= '0;
         s.cfg <= CFG_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule

// ===== hdl/cmd_handler_regs.svh
// Purpose: offsets, command codes, encodings and reset values
// Assumes: 8-bit register offsets, AXI4-Lite word registers
// Notes: included by the package, the assertions and the testbench
`ifndef CMD_HANDLER_REGS_SVH
`define CMD_HANDLER_REGS_SVH
`define OFS_CMD_DATA 8'h00
`define OFS_RSP_DATA 8'h04
`define OFS_STATUS   8'h08
`define OFS_CHAN     8'h0C
`define OFS_SLOT     8'h10
`define OFS_SEQ      8'h14
`define OFS_CTRL     8'h18
`define BIT_LAST     8
`define BIT_FLUSH    0
`define BIT_SEQ_ACK  1
`define BIT_OVR_CLR  2
`define CODE_HI      8'h00
`define CODE_SET_CH  8'h2A
`define CODE_GET_CH  8'h2B
`define CODE_GET_VER 8'h2F
`define CODE_SET_SL  8'h30
`define CODE_GET_SL  8'h31
`define CODE_SET_SEQ 8'h40
`define ERR_HI       8'h42
`define ERR_DATA_LO  8'h0B
`define ERR_SUB_LO   8'h08
`define CHAN_MIN     8'h01
`define CHAN_MAX     8'h05
`define SLOT_MIN     8'h01
`define SLOT_MAX     8'h03
`define SEQ_RSVD     8'h00
`define PROTO_T21    4'h4
`define ACK_MAX      4'h1
`define ANT_MAX      8'h03
`define CHAN_RST     8'h05
`define SLOT_RST     8'h01
`define ACK_RST      4'h0
`define ANT_RST      8'h00
`define LEN_CODE     4'h2
`define LEN_ONE      4'h3
`define LEN_SEQ      4'h5
`define LEN_SUBERR   4'h4
`define VER_BYTES    13
`define CMD_MAX      5
`define RSP_MAX      15
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// ===== hdl/cmd_handler_pkg.sv
// Purpose: types shared by the command handler
// Assumes: constants come from the regs header
// Notes: the whole handler state is one packed struct
package cmd_handler_pkg;
`include "cmd_handler_regs.svh"
   typedef enum logic [1:0] {PH_COLLECT, PH_EXEC, PH_RESPOND} phase_t;
   typedef struct packed {
      logic [7:0] chan;
      logic [7:0] slot;
      logic [3:0] proto;
      logic [3:0] ack_cfg;
      logic [7:0] antenna;
   } cfg_t;
   typedef struct packed {
      phase_t                          phase;
      logic [`CMD_MAX-1:0][7:0]        cmd_buf;
      logic [3:0]                      cmd_cnt;
      logic                            cmd_ovf;
      logic [`RSP_MAX-1:0][7:0]        rsp_buf;
      logic [3:0]                      rsp_len;
      logic [3:0]                      rsp_ptr;
      cfg_t                            cfg;
      logic                            seq_changed;
      logic                            last_err;
      logic                            overrun;
      logic                            aw_held;
      logic [7:0]                      aw_off;
      logic                            aw_hi;
      logic                            w_held;
      logic [31:0]                     wdata;
      logic [3:0]                      wstrb;
      logic                            bvalid;
      logic [1:0]                      bresp;
      logic                            rvalid;
      logic [31:0]                     rdata;
      logic [1:0]                      rresp;
   } state_t;
endpackage

// ===== dv/cmd_handler_assertions.sv
// Purpose: bus and setting checks at the handler ports
// Assumes: one clock; reset low disables every check
// Notes: bound to every handler instance at the foot
`timescale 1ns/1ps
`include "cmd_handler_regs.svh"
module cmd_handler_assertions
   import cmd_handler_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input logic              aclk,
   input logic              aresetn,
   input logic [ADDR_W-1:0] awaddr,
   input logic              awvalid,
   input logic              awready,
   input logic [31:0]       wdata,
   input logic [3:0]        wstrb,
   input logic              wvalid,
   input logic              wready,
   input logic [1:0]        bresp,
   input logic              bvalid,
   input logic              bready,
   input logic [ADDR_W-1:0] araddr,
   input logic              arvalid,
   input logic              arready,
   input logic [31:0]       rdata,
   input logic [1:0]        rresp,
   input logic              rvalid,
   input logic              rready,
   input cfg_t              cfg,
   input logic              seq_reset_req
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // address and data taken at one edge
   sequence wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rd_take;
      arvalid && arready;
   endsequence
   // a setting may only move on the edge after a write answer
   sequence after_write;
      $past(bvalid);
   endsequence
   chk_wr_answer: assert property (wr_take |=> ##1 bvalid)
      else $error("no write answer");
   chk_rd_answer: assert property (rd_take |=> rvalid)
      else $error("no read answer");
   chk_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   chk_ready_low: assert property (bvalid |-> !awready && !wready)
      else $error("ready while answer pending");
   chk_chan_range: assert property (cfg.chan inside {[8'h01:8'h05]})
      else $error("channel out of range");
   chk_slot_range: assert property (cfg.slot inside {[8'h01:8'h03]})
      else $error("slot out of range");
   chk_seq_fields: assert property (cfg.proto == 4'h4 && cfg.ack_cfg <= 4'h1
      && cfg.antenna <= 8'h03)
      else $error("sequence field out of range");
   chk_cfg_cause: assert property ($changed(cfg) |-> after_write)
      else $error("setting moved without command");
   chk_seq_flag: assert property ($changed(cfg[15:0]) |-> ##[0:1] seq_reset_req)
      else $error("sequence change not flagged");
   chk_reset_vals: assert property ($rose(aresetn) |-> !seq_reset_req
      && cfg == {`CHAN_RST, `SLOT_RST, `PROTO_T21, `ACK_RST, `ANT_RST})
      else $error("bad values after reset");
endmodule
bind cmd_handler cmd_handler_assertions #(.ADDR_W(ADDR_W)) chk_u (
   .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
   .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
   .rready, .cfg, .seq_reset_req
);

// ===== dv/host_model.sv
// Purpose: host side of the register bus
// Assumes: one write and one read at most under way
// Notes: payload is inverted once taken, so stale values never pass
`timescale 1ns/1ps
module host_model (
   input  logic        aclk,
   output logic [7:0]  awaddr,
   output logic        awvalid,
   input  logic        awready,
   output logic [31:0] wdata,
   output logic [3:0]  wstrb,
   output logic        wvalid,
   input  logic        wready,
   input  logic [1:0]  bresp,
   input  logic        bvalid,
   output logic        bready,
   output logic [7:0]  araddr,
   output logic        arvalid,
   input  logic        arready,
   input  logic [31:0] rdata,
   input  logic [1:0]  rresp,
   input  logic        rvalid,
   output logic        rready
);
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // flags sampled at the falling edge hold for the next rising edge
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb, tv;
      begin
         tb = 1'b0;
         @(posedge aclk);
         {awaddr, wdata, wstrb} <= {a, d, 4'hf};
         // bready comes up only once the answer is seen, so a held answer is exercised
         {awvalid, wvalid, bready} <= 3'h6;
         for (int k = 0; k < 100 && !tb; k++)
         begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bready && bvalid;
            tv = bvalid;
            r  = bresp;
            @(posedge aclk);
            if (ta)
               {awvalid, awaddr} <= {1'b0, ~a};
            if (tw)
               {wvalid, wdata} <= {1'b0, ~d};
            if (tb)
               bready <= 1'b0;
            else if (tv)
               bready <= 1'b1;
         end
         if (!tb)
            testbench.hang();
      end
   endtask
   // read: address held until taken, rready raised once data seen, held until taken
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tb, tv;
      begin
         tb = 1'b0;
         @(posedge aclk);
         {araddr, arvalid, rready} <= {a, 2'h2};
         for (int k = 0; k < 100 && !tb; k++)
         begin
            @(negedge aclk);
            ta = arvalid && arready;
            tb = rready && rvalid;
            tv = rvalid;
            {d, r} = {rdata, rresp};
            @(posedge aclk);
            if (ta)
               {arvalid, araddr} <= {1'b0, ~a};
            if (tb)
               rready <= 1'b0;
            else if (tv)
               rready <= 1'b1;
         end
         if (!tb)
            testbench.hang();
      end
   endtask
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench of the command handler
// Assumes: host_model speaks the register bus
// Notes: table of plain commands first, awkward cases after
`timescale 1ns/1ps
`include "cmd_handler_regs.svh"
module testbench;
   import cmd_handler_pkg::*;
   localparam logic [103:0] VER = 104'h01_0203_0405_0607_0809_0a0b_0c0d; // arbitrary
   typedef struct packed {
      logic [47:0] c;   // command bytes, first byte highest
      logic [3:0]  n;   // command byte count
      logic [31:0] e;   // expected answer bytes
      logic [3:0]  m;   // answer byte count
   } row_t;
   row_t rows [0:13] = '{
      '{48'h0000_0000_3002, 4'h3, 32'h0000_0030, 4'h2},
      '{48'h0000_0000_3000, 4'h3, 32'h0000_420b, 4'h2},
      '{48'h0000_0000_3004, 4'h3, 32'h0000_420b, 4'h2},
      '{48'h0000_0000_0031, 4'h2, 32'h0000_3102, 4'h3},
      '{48'h0000_0000_2a06, 4'h3, 32'h0000_420b, 4'h2},
      '{48'h0000_0000_2a00, 4'h3, 32'h0000_420b, 4'h2},
      '{48'h0000_0000_002b, 4'h2, 32'h0000_2b05, 4'h3},
      '{48'h0000_4001_4100, 4'h5, 32'h0000_420b, 4'h2},
      '{48'h0000_4000_3100, 4'h5, 32'h0000_420b, 4'h2},
      '{48'h0000_4000_4200, 4'h5, 32'h0000_420b, 4'h2},
      '{48'h0000_4000_4004, 4'h5, 32'h0000_420b, 4'h2},
      '{48'h0000_0000_002c, 4'h2, 32'h4208_002c, 4'h4},
      '{48'h0000_0000_012a, 4'h2, 32'h4208_012a, 4'h4},
      '{48'h0000_0000_3100, 4'h3, 32'h0000_420b, 4'h2}
   };
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, seq_reset_req;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   cfg_t        cfg;
   int          error_cnt, checks;
   cmd_handler #(.ADDR_W(8), .VERSION(VER)) dut_u (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .cfg, .seq_reset_req
   );
   host_model host_u (
      .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
   );
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bytes go out high first; bit 8 marks the final one
   task send(input logic [47:0] c, input int n);
      for (int i = n - 1; i >= 0; i--)
         host_u.wr(`OFS_CMD_DATA, {23'h00_0000, i == 0, c[8*i+:8]}, r);
   endtask
   // pops the answer, then one more pop must find it empty
   task get_rsp(input logic [119:0] e, input int m);
      for (int i = m - 1; i >= 0; i--)
      begin
         host_u.rd(`OFS_RSP_DATA, d, r);
         chk("answer byte", {24'h00_0001, e[8*i+:8]}, d);
      end
      host_u.rd(`OFS_RSP_DATA, d, r);
      chk("answer end", 32'h0000_0000, d);
   endtask
   task hang;
      error_cnt++;
      close_out();
   endtask
   task close_out;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      {error_cnt, checks} = '0;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // version query straight after reset: no precondition
      send(48'h0000_0000_002f, 2);
      get_rsp({16'h002f, VER}, 15);
      foreach (rows[i])
      begin
         send(rows[i].c, int'(rows[i].n));
         get_rsp(120'(rows[i].e), int'(rows[i].m));
      end
      for (int i = 1; i <= 5; i++)
      begin
         send({16'h002a, 8'(i)}, 3);
         get_rsp(16'h002a, 2);
         send(16'h002b, 2);
         get_rsp({16'h002b, 8'(i)}, 3);
         if (i > 3)
            continue;
         send({16'h0030, 8'(i)}, 3);
         get_rsp(16'h0030, 2);
      end
      for (int i = 0; i < 4; i++)
      begin
         send({24'h00_4000, 4'h4, 4'(i % 2), 8'(i)}, 5);
         get_rsp(16'h0040, 2);
         chk("cfg seq", 32'({4'h4, 4'(i % 2), 8'(i)}), 32'(cfg[15:0]));
         chk("seq flag", 32'h0000_0001, 32'(seq_reset_req));
         host_u.wr(`OFS_CTRL, 32'h0000_0002, r);
         chk("seq flag clear", 32'h0000_0000, 32'(seq_reset_req));
      end
      // over-long message and a write to a read-only place keep settings
      send(48'h0030_0100_0000, 6);
      get_rsp(16'h420b, 2);
      host_u.rd(`OFS_STATUS, d, r);
      chk("error bit", 32'h0000_0004, d & 32'h0000_0004);
      host_u.wr(`OFS_CHAN, 32'h0000_0001, r);
      host_u.rd(`OFS_CHAN, d, r);
      chk("chan", 32'h0000_0005, d);
      host_u.rd(`OFS_SLOT, d, r);
      chk("slot", 32'h0000_0003, d);
      host_u.rd(`OFS_SEQ, d, r);
      chk("seq", 32'h0000_0341, d);
      host_u.rd(8'h1c, d, r);
      chk("unmapped read", 32'h0000_0002, 32'(r));
      host_u.wr(8'h1c, 32'h0000_0000, r);
      chk("unmapped write", 32'h0000_0002, 32'(r));
      // a byte arriving while an answer waits is dropped and flagged
      send(48'h0000_0000_2a01, 3);
      host_u.wr(`OFS_CMD_DATA, 32'h0000_0107, r);
      host_u.rd(`OFS_STATUS, d, r);
      chk("overrun", 32'h0000_0008, d & 32'h0000_0008);
      get_rsp(16'h002a, 2);
      host_u.wr(`OFS_CTRL, 32'h0000_0004, r);
      host_u.rd(`OFS_STATUS, d, r);
      chk("overrun clear", 32'h0000_0000, d & 32'h0000_0008);
      // a partial message is thrown away by a flush
      host_u.wr(`OFS_CMD_DATA, 32'h0000_0000, r);
      host_u.rd(`OFS_STATUS, d, r);
      chk("bytes held", 32'h0000_1000, d & 32'h0000_f000);
      host_u.wr(`OFS_CTRL, 32'h0000_0001, r);
      send(48'h0000_0000_0031, 2);
      get_rsp(24'h00_3103, 3);
      // reset in mid-run brings the settings back
      send(48'h0000_4000_4102, 5);
      get_rsp(16'h0040, 2);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk("cfg reset", 32'h0501_4000, cfg);
      chk("flag reset", 32'h0000_0000, 32'(seq_reset_req));
      close_out();
   end
endmodule
